// ===== hdl/io_pin_function_matrix.sv
/*
  Pin function matrix: assigns sixty pads to the parallel port, serial
  peripherals, simple or timed general-purpose I/O, and watches the I/O
  supplies. Assumes peripherals and software ports run on i_ref_clk;
  pads and supply flags are asynchronous and are synchronised here.
*/
// Overview of operation
// - sixty pads, each usable as general-purpose I/O or a peripheral
// - pads go to functions by mode; per-pad overrides take precedence
// - simple pads: software output, readable input, change interrupt
// - timed pads: counter, period, threshold per group; slow/fast tick
// - timer group of a pad is its index modulo eight
// - only the lowest overridden pad of a group gets the timer
// - parallel data, clock, control, strap and hi data placement
// - audio, two-wire, shared data/UART and SPI/UART placement
// - narrow bus: UART on 46-49, SPI on 53-56
// - wide bus: UART on 53-56, no SPI
// - narrow-only part: wide data roles never apply
// - weak pull-up and pull-down per pad
// - all pads undriven after reset until configured
// - data pads go simple by select alone; others need override
// - timed override may be set on any pad
// - supply status, event and mask visible to software
`timescale 1ns/10ps
`include "pin_matrix_consts.svh"
module io_pin_function_matrix (
  input wire logic i_ref_clk, // reference clock, 200 MHz
  input wire logic i_rstn, // async reset, active low
  input wire logic i_sel_wr, // pulse: load pin_function_select
  input wire logic [`SEL_W-1:0] i_pin_function_select, // select word
  input wire logic i_wide_capable, // part supports wide bus (pin)
  input wire logic [`PINS-1:0] i_simple_override, // per pad
  input wire logic [`PINS-1:0] i_timed_override, // per pad
  input wire logic [2*`PINS-1:0] i_drive_strength_cfg, // 2 bits a pad
  input wire logic [`PINS-1:0] i_weak_pullup_cfg, // per pad
  input wire logic [`PINS-1:0] i_weak_pulldown_cfg, // per pad
  input wire logic [`PINS-1:0] i_pad_in, // pad levels
  output logic [`PINS-1:0] o_pad_out, // pad output values
  output logic [`PINS-1:0] o_pad_oe, // pad output enables
  output logic [2*`PINS-1:0] o_pad_ds, // pad drive strengths
  output logic [`PINS-1:0] o_pad_pu, // pad pull-up enables
  output logic [`PINS-1:0] o_pad_pd, // pad pull-down enables
  input wire logic [`PP_PINS-1:0] i_pp_out, // parallel port out, by pad
  input wire logic [`PP_PINS-1:0] i_pp_oe, // parallel port oe, by pad
  output logic [`PP_PINS-1:0] o_pp_in, // parallel port in, by pad
  output logic [2:0] o_strap, // boot strap levels
  input wire logic [3:0] i_uart_out, // uart outputs
  input wire logic [3:0] i_uart_oe, // uart enables
  output logic [3:0] o_uart_in, // uart inputs
  input wire logic [3:0] i_spi_out, // spi outputs
  input wire logic [3:0] i_spi_oe, // spi enables
  output logic [3:0] o_spi_in, // spi inputs
  input wire logic [3:0] i_audio_out, // serial audio outputs
  input wire logic [3:0] i_audio_oe, // serial audio enables
  output logic [3:0] o_audio_in, // serial audio inputs
  input wire logic [1:0] i_twi_drive_low, // two-wire pull low
  output logic [1:0] o_twi_in, // two-wire line levels
  input wire logic [`PINS-1:0] i_gpio_out, // simple gpio out values
  input wire logic [`PINS-1:0] i_gpio_oe, // simple gpio enables
  input wire logic [`PINS-1:0] i_gpio_intr_en, // change irq enables
  output logic [`PINS-1:0] o_gpio_in, // pad input values
  output logic [`PINS-1:0] o_gpio_intr, // pulse: simple pad changed
  input wire logic [`GROUPS-1:0] i_timer_fast_sel, // 1: fast tick
  input wire logic [`GROUPS*`TMR_W-1:0] i_timer_period, // per group
  input wire logic [`GROUPS*`TMR_W-1:0] i_timer_thresh, // per group
  output logic [`GROUPS*`TMR_W-1:0] o_timer_count, // per group
  output logic [`GROUPS-1:0] o_timer_wrap, // pulse: counter wrapped
  input wire logic [`SUPPLIES-1:0] i_io_supply, // supply good levels
  input wire logic [`SUPPLIES-1:0] i_io_supply_event_clr, // pulses
  input wire logic [`SUPPLIES-1:0] i_io_supply_event_mask, // 1: enable
  output logic [`SUPPLIES-1:0] o_io_supply_status, // synced status
  output logic [`SUPPLIES-1:0] o_io_supply_event, // sticky events
  output logic o_io_supply_irq // masked event request
);
  logic [`SEL_W-1:0] sel_reg, sel_next;
  logic cfg_reg, cfg_next;
  logic wide_meta_reg, wide_ok_reg;
  logic [`PINS-1:0] pad_meta_reg, pad_sync_reg, in_reg, intr_next;
  logic [`PINS-1:0] timed_mask, simple_mask, alt_out, alt_oe, tmr_pad;
  pin_matrix_pkg::pin_func_t func [`PINS];
  logic [`TMR_W-1:0] cnt_reg [`GROUPS];
  logic [`TMR_W-1:0] cnt_next [`GROUPS];
  logic [`GROUPS-1:0] wrap_next;
  logic [`SLOW_DIV_W-1:0] div_reg, div_next;
  logic slow_tick;
  logic [`SUPPLIES-1:0] sup_meta_reg, sup_sync_reg, event_next;
  logic [3:0] uart_in_next;
  logic [`GROUPS-1:0] grp_ok;

  // ==========================================================
  // role of a pad from the select word, before overrides
  function automatic pin_matrix_pkg::pin_func_t base_func(
      input int p, input logic [`SEL_W-1:0] sel, input logic wide_ok);
    int bw;
    logic wide;
    logic pp;
    pin_matrix_pkg::pin_func_t f;
    bw = 8 * (int'(sel[1:0]) + 1);
    if (!wide_ok && bw > `NARROW_BITS)
      bw = `NARROW_BITS;
    wide = (bw > `NARROW_BITS);
    pp = sel[`SEL_PP_EN];
    f = pin_matrix_pkg::FN_OFF;
    if (p <= `DQ_LO_LAST)
      f = (pp && p < bw) ? pin_matrix_pkg::FN_PARALLEL
                         : pin_matrix_pkg::FN_SIMPLE;
    else if (p <= `CTL_LAST)
      f = pp ? pin_matrix_pkg::FN_PARALLEL : pin_matrix_pkg::FN_OFF;
    else if (p <= `STRAP_LAST)
      f = pin_matrix_pkg::FN_STRAP;
    else if (p <= `DQ_HI_LAST) begin
      if (wide_ok)
        f = (pp && p - `DQ_HI_FIRST + `DQ_HI_BASE < bw)
            ? pin_matrix_pkg::FN_PARALLEL : pin_matrix_pkg::FN_SIMPLE;
    end else if (p >= `SHARED_A_FIRST && p <= `SHARED_A_LAST) begin
      if (wide)
        f = (pp && p - `SHARED_A_FIRST + `DQ_TOP_BASE < bw)
            ? pin_matrix_pkg::FN_PARALLEL : pin_matrix_pkg::FN_SIMPLE;
      else if (sel[`SEL_UART_EN])
        f = pin_matrix_pkg::FN_UART;
    end else if ((p >= `AUDIO_FIRST && p <= `AUDIO_LAST) ||
                 p == `AUDIO_EXTRA) begin
      if (sel[`SEL_AUDIO_EN])
        f = pin_matrix_pkg::FN_AUDIO;
    end else if (p >= `SHARED_B_FIRST && p <= `SHARED_B_LAST) begin
      // wide bus moves uart, drops spi
      if (wide && sel[`SEL_UART_EN])
        f = pin_matrix_pkg::FN_UART;
      else if (!wide && sel[`SEL_SPI_EN])
        f = pin_matrix_pkg::FN_SPI;
    end else if (p >= `TWI_FIRST && sel[`SEL_TWI_EN])
      f = pin_matrix_pkg::FN_TWI;
    return f;
  endfunction : base_func

  // ==========================================================
  // select register and configured flag
  always_comb begin
    sel_next = sel_reg;
    cfg_next = cfg_reg;
    // roles only after a select load
    if (i_sel_wr) begin
      sel_next = i_pin_function_select;
      cfg_next = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sel_reg <= '0;
      cfg_reg <= 1'b0;
    end else begin
      sel_reg <= sel_next;
      cfg_reg <= cfg_next;
    end
  end

  // ==========================================================
  // role of every pad after overrides
  always_comb begin
    logic found;
    found = 1'b0;
    timed_mask = '0;
    // any pad may ask for timer
    for (int g = 0; g < `GROUPS; g++) begin
      found = 1'b0;
      for (int p = g; p < `PINS; p += `GROUPS) begin
        if (i_timed_override[p] && !found) begin
          timed_mask[p] = 1'b1;
          found = 1'b1;
        end
      end
    end
    for (int p = 0; p < `PINS; p++) begin
      if (!cfg_reg)
        func[p] = pin_matrix_pkg::FN_OFF;
      else if (timed_mask[p])
        func[p] = pin_matrix_pkg::FN_TIMED;
      else if (i_simple_override[p])
        func[p] = pin_matrix_pkg::FN_SIMPLE;
      else
        func[p] = base_func(p, sel_reg, wide_ok_reg);
      simple_mask[p] = (func[p] == pin_matrix_pkg::FN_SIMPLE);
    end
  end

  // ==========================================================
  // peripheral sources lined up by pad index
  always_comb begin
    alt_out = '0;
    alt_oe = '0;
    for (int p = 0; p < `PINS; p++) begin
      case (func[p])
        pin_matrix_pkg::FN_PARALLEL: begin
          if (p < `PP_PINS) begin
            alt_out[p] = i_pp_out[p];
            alt_oe[p] = i_pp_oe[p];
          end
        end
        pin_matrix_pkg::FN_UART: begin
          alt_out[p] = (p >= `SHARED_B_FIRST)
              ? i_uart_out[(p - `SHARED_B_FIRST) % 4]
              : i_uart_out[(p - `SHARED_A_FIRST) % 4];
          alt_oe[p] = (p >= `SHARED_B_FIRST)
              ? i_uart_oe[(p - `SHARED_B_FIRST) % 4]
              : i_uart_oe[(p - `SHARED_A_FIRST) % 4];
        end
        pin_matrix_pkg::FN_SPI: begin
          alt_out[p] = i_spi_out[(p - `SHARED_B_FIRST) % 4];
          alt_oe[p] = i_spi_oe[(p - `SHARED_B_FIRST) % 4];
        end
        pin_matrix_pkg::FN_AUDIO: begin
          alt_out[p] = (p == `AUDIO_EXTRA) ? i_audio_out[3]
              : i_audio_out[(p - `AUDIO_FIRST) % 4];
          alt_oe[p] = (p == `AUDIO_EXTRA) ? i_audio_oe[3]
              : i_audio_oe[(p - `AUDIO_FIRST) % 4];
        end
        pin_matrix_pkg::FN_TWI: begin
          alt_out[p] = 1'b0;
          alt_oe[p] = i_twi_drive_low[(p - `TWI_FIRST) % 2];
        end
        default: begin
          alt_out[p] = 1'b0;
          alt_oe[p] = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // one slot per pad
  for (genvar p = 0; p < `PINS; p++) begin : g_slot
    pin_slot u_slot (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .i_func(func[p]),
      .i_alt_out(alt_out[p]),
      .i_alt_oe(alt_oe[p]),
      .i_gpio_out(i_gpio_out[p]),
      .i_gpio_oe(i_gpio_oe[p]),
      .i_tmr_out(tmr_pad[p]),
      .i_ds(i_drive_strength_cfg[2*p +: 2]),
      .i_pu(i_weak_pullup_cfg[p]),
      .i_pd(i_weak_pulldown_cfg[p]),
      .o_pad_out(o_pad_out[p]),
      .o_pad_oe(o_pad_oe[p]),
      .o_pad_ds(o_pad_ds[2*p +: 2]),
      .o_pad_pu(o_pad_pu[p]),
      .o_pad_pd(o_pad_pd[p])
    );
  end

  // ==========================================================
  // group timers: counter wraps at period, pad high below threshold
  always_comb begin
    div_next = (div_reg == `SLOW_DIV_W'(`SLOW_DIV - 1))
        ? '0 : div_reg + 1'b1;
    slow_tick = (div_reg == `SLOW_DIV_W'(`SLOW_DIV - 1));
    for (int g = 0; g < `GROUPS; g++) begin
      cnt_next[g] = cnt_reg[g];
      wrap_next[g] = 1'b0;
      if (i_timer_fast_sel[g] || slow_tick) begin
        if (cnt_reg[g] >= i_timer_period[g*`TMR_W +: `TMR_W]) begin
          cnt_next[g] = '0;
          wrap_next[g] = 1'b1;
        end else
          cnt_next[g] = cnt_reg[g] + 1'b1;
      end
    end
    for (int p = 0; p < `PINS; p++)
      tmr_pad[p] = cnt_reg[p % `GROUPS] <
          i_timer_thresh[(p % `GROUPS)*`TMR_W +: `TMR_W];
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_reg <= '0;
      o_timer_wrap <= '0;
      for (int g = 0; g < `GROUPS; g++)
        cnt_reg[g] <= '0;
    end else begin
      div_reg <= div_next;
      o_timer_wrap <= wrap_next;
      for (int g = 0; g < `GROUPS; g++)
        cnt_reg[g] <= cnt_next[g];
    end
  end

  for (genvar g = 0; g < `GROUPS; g++) begin : g_cnt
    assign o_timer_count[g*`TMR_W +: `TMR_W] = cnt_reg[g];
  end

  // ==========================================================
  // pad inputs and supply flags: two-flop synchronisers, then registers
  always_comb begin
    intr_next = i_gpio_intr_en & simple_mask & (pad_sync_reg ^ in_reg);
    uart_in_next = (func[`SHARED_B_FIRST] == pin_matrix_pkg::FN_UART)
        ? pad_sync_reg[`SHARED_B_LAST:`SHARED_B_FIRST]
        : pad_sync_reg[`SHARED_A_LAST:`SHARED_A_FIRST];
    event_next = (o_io_supply_event & ~i_io_supply_event_clr) |
        (sup_sync_reg ^ o_io_supply_status);
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pad_meta_reg <= '0;
      pad_sync_reg <= '0;
      in_reg <= '0;
      o_gpio_intr <= '0;
      o_uart_in <= '0;
      wide_meta_reg <= 1'b0;
      wide_ok_reg <= 1'b0;
      sup_meta_reg <= '0;
      sup_sync_reg <= '0;
      o_io_supply_status <= '0;
      o_io_supply_event <= '0;
      o_io_supply_irq <= 1'b0;
    end else begin
      pad_meta_reg <= i_pad_in;
      pad_sync_reg <= pad_meta_reg;
      in_reg <= pad_sync_reg;
      o_gpio_intr <= intr_next;
      o_uart_in <= uart_in_next;
      wide_meta_reg <= i_wide_capable;
      wide_ok_reg <= wide_meta_reg;
      sup_meta_reg <= i_io_supply;
      sup_sync_reg <= sup_meta_reg;
      o_io_supply_status <= sup_sync_reg;
      o_io_supply_event <= event_next;
      o_io_supply_irq <= |(event_next & i_io_supply_event_mask);
    end
  end

  assign o_gpio_in = in_reg;
  assign o_pp_in = in_reg[`PP_PINS-1:0];
  assign o_strap = in_reg[`STRAP_LAST:`STRAP_FIRST];
  assign o_spi_in = in_reg[`SHARED_B_LAST:`SHARED_B_FIRST];
  assign o_audio_in = {in_reg[`AUDIO_EXTRA], in_reg[`AUDIO_LAST:`AUDIO_FIRST]};
  assign o_twi_in = in_reg[`PINS-1:`TWI_FIRST];

  // ==========================================================
  // checks
  always_comb begin
    for (int g = 0; g < `GROUPS; g++) begin
      grp_ok[g] = 1'b1;
      for (int p = g + `GROUPS; p < `PINS; p += `GROUPS)
        for (int q = g; q < p; q += `GROUPS)
          if (func[p] == pin_matrix_pkg::FN_TIMED &&
              func[q] == pin_matrix_pkg::FN_TIMED)
            grp_ok[g] = 1'b0;
    end
  end

  property p_undriven;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      !cfg_reg |=> (o_pad_oe == '0);
  endproperty
  a_undriven: assert property (p_undriven)
    else $error("pad driven before configuration");

  property p_one_timed;
    @(posedge i_ref_clk) disable iff (!i_rstn) &grp_ok;
  endproperty
  a_one_timed: assert property (p_one_timed)
    else $error("two timed pads in one group");

  property p_drive;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      ##1 o_pad_ds == $past(i_drive_strength_cfg);
  endproperty
  a_drive: assert property (p_drive)
    else $error("drive strength not applied");

  property p_irq;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      ##1 o_io_supply_irq ==
        |(o_io_supply_event & $past(i_io_supply_event_mask));
  endproperty
  a_irq: assert property (p_irq)
    else $error("supply irq does not match masked events");

  property p_event_set;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (sup_sync_reg != o_io_supply_status) |=>
        ((o_io_supply_event & $past(sup_sync_reg ^ o_io_supply_status))
         == $past(sup_sync_reg ^ o_io_supply_status));
  endproperty
  a_event_set: assert property (p_event_set)
    else $error("supply change not latched");

  property p_uart_wide;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (cfg_reg && wide_ok_reg && sel_reg[1] && sel_reg[`SEL_UART_EN]
       && !i_timed_override[`SHARED_B_FIRST]
       && !i_simple_override[`SHARED_B_FIRST])
      |=> o_pad_oe[`SHARED_B_FIRST] == $past(i_uart_oe[0]);
  endproperty
  a_uart_wide: assert property (p_uart_wide)
    else $error("uart not moved on wide bus");

  property p_spi_narrow;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (cfg_reg && !sel_reg[1] && sel_reg[`SEL_SPI_EN]
       && !i_timed_override[`SHARED_B_FIRST]
       && !i_simple_override[`SHARED_B_FIRST])
      |=> o_pad_out[`SHARED_B_FIRST] == $past(i_spi_out[0]);
  endproperty
  a_spi_narrow: assert property (p_spi_narrow)
    else $error("spi missing on narrow bus");

  property p_twi;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      ##1 (o_pad_out[`TWI_FIRST] == 1'b0 || !o_pad_oe[`TWI_FIRST]
           || $past(func[`TWI_FIRST]) != pin_matrix_pkg::FN_TWI);
  endproperty
  a_twi: assert property (p_twi)
    else $error("two-wire pad driven high");

  property p_wrap;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      o_timer_wrap[0] |-> o_timer_count[`TMR_W-1:0] == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("timer wrap without reload");
endmodule : io_pin_function_matrix

// ===== hdl/pin_matrix_consts.svh
/*
  Constants for the pin function matrix: pin counts, pin boundaries of
  each function, layout of the function select word and timer counts.
  Assumes it is included by bare name from the design files.
*/
`ifndef PIN_MATRIX_CONSTS_SVH
`define PIN_MATRIX_CONSTS_SVH

`define PINS 60
`define GROUPS 8
`define SUPPLIES 8
`define TMR_W 16
// pin boundaries of each alternate function
`define DQ_LO_LAST 15
`define CTL_LAST 29
`define STRAP_FIRST 30
`define STRAP_LAST 32
`define DQ_HI_FIRST 33
`define DQ_HI_LAST 44
`define SHARED_A_FIRST 46
`define SHARED_A_LAST 49
`define AUDIO_FIRST 50
`define AUDIO_LAST 52
`define SHARED_B_FIRST 53
`define SHARED_B_LAST 56
`define AUDIO_EXTRA 57
`define TWI_FIRST 58
`define PP_PINS 50
`define DQ_HI_BASE 16
`define DQ_TOP_BASE 28
`define NARROW_BITS 16
// pin_function_select word layout
`define SEL_W 7
`define SEL_PP_EN 2
`define SEL_UART_EN 3
`define SEL_SPI_EN 4
`define SEL_AUDIO_EN 5
`define SEL_TWI_EN 6
// slow timer tick derived from the reference clock
`define CLK_PERIOD_NS 5
`define SLOW_TICK_NS 1000
`define SLOW_DIV (`SLOW_TICK_NS / `CLK_PERIOD_NS)
`define SLOW_DIV_W 8

`endif

// ===== hdl/pin_matrix_pkg.sv
/*
  Types shared by the pin function matrix and its per-pin slot.
  Assumes nothing of its surroundings.
*/
package pin_matrix_pkg;
  // parallel port width code held in the low select bits
  typedef enum logic [1:0] {BW_8, BW_16, BW_24, BW_32} bus_width_t;
  // role a pin currently plays
  typedef enum logic [3:0] {
    FN_OFF, FN_PARALLEL, FN_STRAP, FN_UART, FN_SPI, FN_AUDIO, FN_TWI,
    FN_SIMPLE, FN_TIMED
  } pin_func_t;
endpackage : pin_matrix_pkg

// ===== hdl/pin_slot.sv
/*
  One pad slot: picks the driver of a pad from its role and registers
  the pad controls. Assumes the role and all sources share i_ref_clk.
*/
`timescale 1ns/10ps
module pin_slot (
  input wire logic i_ref_clk, // reference clock
  input wire logic i_rstn, // async reset, active low
  input wire pin_matrix_pkg::pin_func_t i_func, // current role
  input wire logic i_alt_out, // peripheral output value
  input wire logic i_alt_oe, // peripheral output enable
  input wire logic i_gpio_out, // software output value
  input wire logic i_gpio_oe, // software output enable
  input wire logic i_tmr_out, // timer waveform
  input wire logic [1:0] i_ds, // drive strength level
  input wire logic i_pu, // weak pull-up request
  input wire logic i_pd, // weak pull-down request
  output logic o_pad_out, // pad output value
  output logic o_pad_oe, // pad output enable
  output logic [1:0] o_pad_ds, // pad drive strength
  output logic o_pad_pu, // pad pull-up enable
  output logic o_pad_pd // pad pull-down enable
);
  logic out_next;
  logic oe_next;

  // ==========================================================
  // driver selection
  always_comb begin
    out_next = 1'b0;
    oe_next = 1'b0;
    case (i_func)
      pin_matrix_pkg::FN_PARALLEL, pin_matrix_pkg::FN_UART,
      pin_matrix_pkg::FN_SPI, pin_matrix_pkg::FN_AUDIO,
      pin_matrix_pkg::FN_TWI: begin
        out_next = i_alt_out;
        oe_next = i_alt_oe;
      end
      pin_matrix_pkg::FN_SIMPLE: begin
        out_next = i_gpio_out;
        oe_next = i_gpio_oe;
      end
      pin_matrix_pkg::FN_TIMED: begin
        out_next = i_tmr_out;
        oe_next = 1'b1;
      end
      default: begin
        out_next = 1'b0; // straps and unused pins stay undriven
        oe_next = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // pad registers; strength and pull-up follow software in every role, pull-down only when pull-up is off
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pad_out <= 1'b0;
      o_pad_oe <= 1'b0;
      o_pad_ds <= 2'h0;
      o_pad_pu <= 1'b0;
      o_pad_pd <= 1'b0;
    end else begin
      o_pad_out <= out_next;
      o_pad_oe <= oe_next;
      o_pad_ds <= i_ds;
      o_pad_pu <= i_pu;
      o_pad_pd <= i_pd & ~i_pu;
    end
  end
endmodule : pin_slot

// ===== sim/pad_far_side.sv
/*
  Far side of the pads: resolves each pad level from its driver and
  weak pulls. Assumes pad controls come straight from the matrix.
*/
`timescale 1ns/10ps
module pad_far_side (
  input wire logic i_ref_clk, // clock for the float pattern
  input wire logic [59:0] i_out, // pad output values
  input wire logic [59:0] i_oe, // pad output enables
  input wire logic [59:0] i_pu, // pull-up enables
  input wire logic [59:0] i_pd, // pull-down enables
  output logic [59:0] o_level // resolved pad levels
);
  logic [59:0] flt_reg = '0;
  // a floating pad toggles every cycle, so no stale level is trusted
  always @(posedge i_ref_clk) flt_reg <= ~flt_reg;
  assign o_level = (i_oe & i_out) | (~i_oe & (i_pu | (~i_pd & flt_reg)));
endmodule : pad_far_side

// ===== sim/tb_top.sv
/*
  Bench for the pin matrix: drives roles, pulls, strength and supply
  flags; a watcher checks queued notes. Assumes one 200 MHz clock.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  fails++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb_top;
  logic clk = 0, rstn = 0, sel_wr = 0, wide = 0;
  logic [6:0] sel = '0;
  logic [59:0] simp = '0, pu = '0, pd = '0, gpo = '0, gpoe = '0, pad;
  logic [59:0] p_out, p_oe, p_pu, p_pd, gin, tmo = '0;
  logic [119:0] ds = '0, p_ds;
  logic [3:0] uo = '0, uoe = '0, so = '0, soe = '0;
  logic [7:0] sup = '0, clr = '0, msk = '0, st, ev, e_now;
  logic irq;
  logic [255:0] nz = '0;
  logic [31:0] rnd = 32'h739A;
  int fails = 0, samples_checked = 0, k_now;
  logic [7:0] eq[$];
  int kq[$];
  io_pin_function_matrix io_pin_function_matrix_inst (
    .i_ref_clk(clk), .i_rstn(rstn), .i_sel_wr(sel_wr),
    .i_pin_function_select(sel), .i_wide_capable(wide),
    .i_simple_override(simp), .i_timed_override(tmo),
    .i_drive_strength_cfg(ds), .i_weak_pullup_cfg(pu),
    .i_weak_pulldown_cfg(pd), .i_pad_in(pad), .o_pad_out(p_out),
    .o_pad_oe(p_oe), .o_pad_ds(p_ds), .o_pad_pu(p_pu), .o_pad_pd(p_pd),
    .i_pp_out(nz[49:0]), .i_pp_oe(nz[99:50]), .o_pp_in(), .o_strap(),
    .i_uart_out(uo), .i_uart_oe(uoe), .o_uart_in(), .i_spi_out(so),
    .i_spi_oe(soe), .o_spi_in(), .i_audio_out(nz[103:100]),
    .i_audio_oe(nz[107:104]), .o_audio_in(), .i_twi_drive_low(nz[109:108]),
    .o_twi_in(), .i_gpio_out(gpo), .i_gpio_oe(gpoe),
    .i_gpio_intr_en(nz[169:110]), .o_gpio_in(gin), .o_gpio_intr(),
    .i_timer_fast_sel(nz[177:170]),
    .i_timer_period({nz[127:16], 12'h000, nz[3:0]}),
    .i_timer_thresh({nz[255:144], 16'h0000}), .o_timer_count(),
    .o_timer_wrap(),
    .i_io_supply(sup), .i_io_supply_event_clr(clr),
    .i_io_supply_event_mask(msk), .o_io_supply_status(st),
    .o_io_supply_event(ev), .o_io_supply_irq(irq));
  pad_far_side pad_far_side_inst (.i_ref_clk(clk), .i_out(p_out),
    .i_oe(p_oe), .i_pu(p_pu), .i_pd(p_pd), .o_level(pad));
  // ========================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic [7:0] probe(input int k);
    case (k)
      0: return {7'h00, |p_oe};
      1: return p_ds[7:0];
      2: return {p_pu[3:0], p_pd[3:0]};
      3: return {p_oe[49:46], p_out[49:46]};
      4: return {p_oe[56:53], p_out[56:53]};
      5: return {5'h00, p_oe[0], p_oe[45], p_out[45]};
      7: return {2'b00, gin[8], gin[0], p_out[8], p_out[0], p_oe[8], p_oe[0]};
      default: return {5'h00, irq, ev[0], st[0]};
    endcase
  endfunction : probe
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  task automatic note(input int k, input logic [7:0] v);
    kq.push_back(k);
    eq.push_back(v);
  endtask : note
  task automatic load(input logic [6:0] s);
    @(posedge clk);
    sel <= s;
    sel_wr <= 1'b1;
    @(posedge clk);
    sel_wr <= 1'b0;
    step(4);
  endtask : load
  task automatic wrap_up;
    $display("compared %0d, mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  // ========================================
  // clock, random source and watcher
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    rnd <= lfsr(rnd);
    nz <= {nz[223:0], rnd};
  end
  // one note per falling edge, when outputs have settled
  always @(negedge clk) begin
    if (kq.size() > 0) begin
      k_now = kq.pop_front();
      e_now = eq.pop_front();
      `CHK(probe(k_now), e_now)
    end
  end
  // hang guard
  initial begin
    step(20000);
    fails++;
    wrap_up();
  end
  // ========================================
  // main sequence
  initial begin
    step(4);
    note(0, 8'h00);
    step(1);
    rstn <= 1'b1;
    simp[45] <= 1'b1;
    gpoe <= '1;
    step(4);
    note(0, 8'h00);
    ds <= {rnd[23:0], {3{rnd}}};
    pu <= {rnd[27:0], rnd};
    pd <= nz[59:0];
    step(2);
    note(1, ds[7:0]);
    note(2, {pu[3:0], pd[3:0] & ~pu[3:0]});
    uoe <= 4'hF;
    soe <= 4'hF;
    for (int i = 0; i < 3; i++) begin
      wide <= (i < 2);
      uo <= rnd[3:0];
      so <= rnd[7:4];
      load((i == 0) ? 7'h19 : 7'h1A);
      if (i == 1) note(4, {4'hF, uo});
      else note(3, {4'hF, uo});
      if (i != 1) note(4, {4'hF, so});
    end
    gpo <= {rnd[27:0], rnd};
    step(3);
    note(5, {5'h00, 2'b11, gpo[45]});
    msk <= 8'h01;
    sup <= 8'h01;
    step(6);
    note(6, 8'h07);
    clr <= 8'h01;
    step(1);
    clr <= 8'h00;
    step(3);
    note(6, 8'h01);
    msk <= 8'h00;
    sup <= 8'h00;
    step(6);
    note(6, 8'h02);
    // group 0 threshold is zero, so the timed pad holds low against gpo
    tmo <= 60'h000_0000_0000_0101;
    gpo <= '1;
    step(6);
    note(7, 8'h2B);
    step(3);
    wrap_up();
  end
endmodule : tb_top
